// ### core/ptsc_defines.svh
// Constants for the pulse to stroke converter
`ifndef PTSC_DEFINES_SVH
`define PTSC_DEFINES_SVH
`define PTSC_CLK_HZ 50000000
`define PTSC_MEM_MAX 17'h0ffff
`define PTSC_BATCH_MIN 16'h0001
`define PTSC_FACT_ONE 14'h0064
`define PTSC_FACT_MAX 14'h270f
`define PTSC_FACT_MIN 14'h0001
`define PTSC_RATE_RESET 8'hc8
`define PTSC_STROKE_PULSE_CYC 8'h10
`endif

// ### core/ptsc_pkg.sv
// Types for the pulse to stroke converter
package ptsc_pkg;
  typedef enum logic [1:0] {
    PTSC_MODE_MANUAL = 2'h0,
    PTSC_MODE_BATCH = 2'h1,
    PTSC_MODE_CONTACT = 2'h2
  } ptsc_mode_t;
endpackage

// ### core/ptsc_sync.sv
`timescale 1ns/100ps
// Three-stage input synchroniser with agreement filter and rise pulse
module ptsc_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Async input and filtered outputs
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic [2:0] sync_q;
  logic level_q;
  logic rise_q;
  wire agree = (sync_q[1] == sync_q[2]);
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], async_i};
      if (agree) begin
        level_q <= sync_q[2];
      end
      rise_q <= agree & sync_q[2] & ~level_q;
    end
  end
  assign level_o = level_q;
  assign rise_o = rise_q;
endmodule

// ### core/ptsc_top.sv
// Pulse to stroke converter: batch and contact modes with stroke memory
//
// What this block does
// - Batch count is an integer from one to 65535, never zero.
// - A batch starts on the start key or an external pulse.
// - Unexecuted strokes wait in a stroke memory drained per stroke.
// - Changing mode leaves the configured stroke rate untouched.
// - With accumulate on, pending strokes sum up to 65535.
// - Overflowing the stroke memory puts the block into fault.
// - In contact mode pulses produce single strokes or stroke series.
// - Contact factor is 0.01 to 99.99 in hundredths.
// - Total strokes equal factor times number of pulses.
// - Fraction remainders accumulate; reaching one gives an extra stroke.
// - A reduction factor gives one stroke per group reaching one.
// - Factor 0.75 strokes after two, one, one pulses, repeating.
// - Without accumulate, stop/start or pause clears the stroke memory.
`timescale 1ns/100ps
`include "ptsc_defines.svh"
module ptsc_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Configuration
  input wire ptsc_pkg::ptsc_mode_t mode_i,
  input wire logic [7:0] stroke_rate_i,
  input wire logic [15:0] batch_count_i,
  input wire logic [13:0] factor_i,
  input wire logic accumulate_i,
  // Keys and external control
  input wire logic start_key_i,
  input wire logic stop_start_key_i,
  input wire logic pause_i,
  input wire logic ext_pulse_i,
  input wire logic fault_clear_i,
  // Outputs
  output logic stroke_o,
  output logic fault_o,
  output logic [15:0] mem_count_o,
  output logic running_o
);
  import ptsc_pkg::*;

  localparam int unsigned MIN_PER_S = 60;
  localparam int unsigned CYC_PER_MIN = `PTSC_CLK_HZ * MIN_PER_S;

  logic pulse_rise;
  logic pause_lvl;
  logic [16:0] mem_q;
  logic [13:0] frac_q;
  logic [31:0] gap_q;
  logic [7:0] width_q;
  logic fault_q;
  logic run_q;
  logic stroke_q;
  logic start_edge;
  logic stop_edge;
  logic pause_edge;

  ptsc_sync u_pulse (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i(ext_pulse_i),
    .level_o(),
    .rise_o(pulse_rise)
  );

  ptsc_sync u_pause (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i(pause_i),
    .level_o(pause_lvl),
    .rise_o(pause_edge)
  );

  // Keys are pins too, so they get the same three-stage filter
  ptsc_sync u_start (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i(start_key_i),
    .level_o(),
    .rise_o(start_edge)
  );

  ptsc_sync u_stop (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i(stop_start_key_i),
    .level_o(),
    .rise_o(stop_edge)
  );

  function automatic logic [13:0] clamp_factor(input logic [13:0] raw);
    if (raw < `PTSC_FACT_MIN) begin
      return `PTSC_FACT_MIN;
    end
    if (raw > `PTSC_FACT_MAX) begin
      return `PTSC_FACT_MAX;
    end
    return raw;
  endfunction

  // Out-of-range settings fall back to the nearest legal factor
  wire [13:0] fact = clamp_factor(factor_i);
  wire [15:0] batch = (batch_count_i == 16'h0) ? `PTSC_BATCH_MIN : batch_count_i;

  wire [13:0] whole = fact / `PTSC_FACT_ONE;
  wire [13:0] part = fact % `PTSC_FACT_ONE;
  wire [14:0] frac_sum = {1'b0, frac_q} + {1'b0, part};
  // Carry gives the 2/1/1 pattern at 0.75
  wire carry = (frac_sum >= {1'b0, `PTSC_FACT_ONE});
  wire [13:0] frac_d = carry ? 14'(frac_sum - {1'b0, `PTSC_FACT_ONE}) : frac_sum[13:0];
  wire [16:0] contact_add = {3'h0, whole} + {16'h0, carry};

  wire is_batch = (mode_i == PTSC_MODE_BATCH);
  wire is_contact = (mode_i == PTSC_MODE_CONTACT);
  wire batch_trig = is_batch & (start_edge | pulse_rise);
  wire contact_trig = is_contact & pulse_rise;
  wire [16:0] batch_add = {1'b0, batch};
  wire [16:0] add = batch_trig ? batch_add : (contact_trig ? contact_add : 17'h0);

  // Rate is only ever read from configuration
  wire [7:0] rate = (stroke_rate_i == 8'h0) ? 8'h1 : stroke_rate_i;
  // Stroke interval from rate
  // Slowest rate needs about 3e9 cycles, hence a 32-bit interval counter
  wire [31:0] gap_cyc = 32'(CYC_PER_MIN / rate);

  wire clear_mem = (stop_edge | pause_edge) & ~accumulate_i;
  // Fault, pause or stop hold strokes
  wire can_stroke = run_q & ~fault_q & ~pause_lvl & (mem_q != 17'h0) & (gap_q == 32'h0);
  wire [16:0] drained = mem_q - {16'h0, can_stroke};
  wire [17:0] sum = {1'b0, drained} + {1'b0, add};
  wire overflow = (sum > {1'b0, `PTSC_MEM_MAX});

  // Stop/start key toggles the run state
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      run_q <= 1'b1;
    end else if (stop_edge) begin
      run_q <= ~run_q;
    end
  end

  // Fraction only moves on a counted contact pulse
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      frac_q <= 14'h0;
    end else if (contact_trig) begin
      frac_q <= frac_d;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mem_q <= 17'h0;
    end else if (clear_mem) begin
      mem_q <= 17'h0;
    end else if (overflow) begin
      mem_q <= `PTSC_MEM_MAX;
    end else begin
      mem_q <= sum[16:0];
    end
  end

  // Overflow sets fault, set beats clear
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      fault_q <= 1'b0;
    end else if (overflow & ~clear_mem) begin
      fault_q <= 1'b1;
    end else if (fault_clear_i) begin
      fault_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      gap_q <= 32'h0;
    end else if (can_stroke) begin
      gap_q <= gap_cyc - 32'h1;
    end else if (gap_q != 32'h0) begin
      gap_q <= gap_q - 32'h1;
    end
  end

  // Stroke output width counter
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      width_q <= 8'h0;
    end else if (can_stroke) begin
      width_q <= `PTSC_STROKE_PULSE_CYC;
    end else if (width_q != 8'h0) begin
      width_q <= width_q - 8'h1;
    end
  end

  // Stroke stays high for the whole width
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      stroke_q <= 1'b0;
    end else begin
      stroke_q <= can_stroke | (width_q > 8'h1);
    end
  end

  assign stroke_o = stroke_q;
  assign fault_o = fault_q;
  assign mem_count_o = mem_q[15:0];
  assign running_o = run_q;
endmodule

// ### verification/ptsc_meter.sv
// Contact meter pulse source
`timescale 1ns/100ps
module ptsc_meter (
  // Clock in, pulse out
  input wire logic clock_i,
  output logic ext_pulse_o = 1'b0
);
  // Long phases so the input filter agrees
  task automatic send();
    ext_pulse_o = 1'b1;
    repeat (6) @(negedge clock_i);
    ext_pulse_o = 1'b0;
    repeat (14) @(negedge clock_i);
  endtask
endmodule

// ### verification/ptsc_properties.sv
// Checker on the converter ports
`timescale 1ns/100ps
module ptsc_properties (
  // Watched ports
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic accumulate_i,
  input wire logic stop_start_key_i,
  input wire logic fault_clear_i,
  input wire logic stroke_o,
  input wire logic fault_o,
  input wire logic [15:0] mem_count_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  mem_drain_a: assert property ($rose(stroke_o) |-> |$past(mem_count_o)) else $error("drain");
  stroke_len_a: assert property ($rose(stroke_o) |-> ##15 stroke_o ##1 !stroke_o) else $error("len");
  fault_quiet_a: assert property ($past(fault_o) |-> !$rose(stroke_o)) else $error("quiet");
  fault_stay_a: assert property (fault_o && !fault_clear_i |=> fault_o) else $error("stay");
  fault_clear_a: assert property (fault_o && fault_clear_i |=> !fault_o) else $error("clear");
  overflow_sat_a: assert property ($rose(fault_o) |-> &mem_count_o) else $error("sat");
  stop_clear_a: assert property ($rose(stop_start_key_i) && !accumulate_i |-> ##[1:8] ~|mem_count_o)
    else $error("stop");
  keep_mem_a: assert property ($rose(stop_start_key_i) && accumulate_i && mem_count_o > 16'h1 |-> ##6 |mem_count_o)
    else $error("keep");
  cover property ($rose(stroke_o));
  cover property ($rose(fault_o));
  cover property ($fell(fault_o));
endmodule
bind ptsc_top ptsc_properties u_chk (
  .clock_i(clock_i),
  .reset_i(reset_i),
  .accumulate_i(accumulate_i),
  .stop_start_key_i(stop_start_key_i),
  .fault_clear_i(fault_clear_i),
  .stroke_o(stroke_o),
  .fault_o(fault_o),
  .mem_count_o(mem_count_o)
);

// ### verification/pulse_to_stroke_converter_test.sv
// Bench for the converter
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("unexpected %0t %h %h", $time, a, e); end end
module pulse_to_stroke_converter_test;
  import ptsc_pkg::*;
  logic clock_i = 0, reset_i = 1, acc = 0, start = 0, stop = 0, clr = 0, pause = 0, ext, stroke, fault, run;
  logic [15:0] bcount = 16'h0001;
  ptsc_mode_t mode = PTSC_MODE_CONTACT;
  logic [13:0] fac = 14'h0001;
  logic [15:0] mem;
  int failures = 0, tests_run = 0, strokes = 0;
  initial forever #10 clock_i = ~clock_i;
  always @(posedge stroke) strokes++;
  ptsc_meter u_src (.clock_i(clock_i), .ext_pulse_o(ext));
  // Pulse-driven rate set to the recommended 200 per minute
  ptsc_top u_dut (.clock_i(clock_i), .reset_i(reset_i), .mode_i(mode),
    .stroke_rate_i(8'hc8), .batch_count_i(bcount), .factor_i(fac), .accumulate_i(acc), .start_key_i(start),
    .stop_start_key_i(stop), .pause_i(pause), .ext_pulse_i(ext), .fault_clear_i(clr), .stroke_o(stroke),
    .fault_o(fault), .mem_count_o(mem), .running_o(run));
  task automatic rst();
    reset_i = 1;
    repeat (3) @(negedge clock_i);
    reset_i = 0;
    strokes = 0;
    repeat (2) @(negedge clock_i);
  endtask
  task automatic press(ref logic k);
    k = 1;
    repeat (4) @(negedge clock_i);
    k = 0;
    repeat (8) @(negedge clock_i);
  endtask
  task automatic t_contact();
    int fs[4] = '{75, 10, 125, 9999};
    mode = PTSC_MODE_CONTACT;
    foreach (fs[i]) begin
      fac = 14'(fs[i]);
      rst();
      for (int k = 1; k < 9; k++) begin
        u_src.send();
        `CHK(mem + strokes, fs[i] * k / 100)
      end
      `CHK(strokes, (fs[i] * 8 >= 100) ? 1 : 0)
    end
    press(stop);
    `CHK(mem, 16'h0)
    u_src.send();
    pause = 1;
    repeat (8) @(negedge clock_i);
    pause = 0;
    `CHK(mem, 16'h0)
    repeat (8) @(negedge clock_i);
    $display("contact done");
  endtask
  task automatic t_full();
    acc = 1;
    mode = PTSC_MODE_BATCH;
    bcount = 16'hffff;
    rst();
    press(start);
    press(stop);
    `CHK(run, 1'b0)
    press(stop);
    `CHK(run, 1'b1)
    `CHK(mem + strokes, 65535)
    pause = 1;
    repeat (8) @(negedge clock_i);
    pause = 0;
    repeat (8) @(negedge clock_i);
    `CHK(mem + strokes, 65535)
    u_src.send();
    `CHK({fault, mem}, 17'h1ffff)
    clr = 1;
    @(negedge clock_i);
    clr = 0;
    `CHK(fault, 1'b0)
    $display("full done");
  endtask
  task automatic t_batch();
    mode = PTSC_MODE_BATCH;
    acc = 0;
    bcount = 16'h0000;
    rst();
    press(start);
    `CHK(mem + strokes, 1)
    bcount = 16'h0005;
    u_src.send();
    `CHK(mem + strokes, 6)
    $display("batch done");
  endtask
  task automatic close_out();
    $display("runs %0d bad %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    t_contact();
    t_batch();
    t_full();
    close_out();
  end
endmodule
